// [rtl/shs_consts.svh]
// Constants of the servo homing sequencer: register map, field codes, timing
`ifndef SHS_CONSTS_SVH
`define SHS_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define SHS_OFF_CTRL 12'h000
`define SHS_OFF_TRIG 12'h004
`define SHS_OFF_METHOD 12'h008
`define SHS_OFF_OFFSET 12'h00C
`define SHS_OFF_HIGH_SPD 12'h010
`define SHS_OFF_LOW_SPD 12'h014
`define SHS_OFF_TIME_LIM 12'h018
`define SHS_OFF_STATUS 12'h01C
`define SHS_OFF_POS_FB 12'h020
// ==========================================================
// Control register fields
`define SHS_CTRL_ENABLE 0
`define SHS_CTRL_APPLY_MODE 1
// ==========================================================
// Trigger codes
`define SHS_TRIG_NONE 3'h0
`define SHS_TRIG_ELEC 3'h5
`define SHS_TRIG_CURPOS 3'h6
// ==========================================================
// Method codes
`define SHS_METHOD_MAX 6'h04
`define SHS_METHOD_CIA_MAX 6'h22
// ==========================================================
// Reset values
`define SHS_HIGH_SPD_RST 32'h0000_0064
`define SHS_LOW_SPD_RST 32'h0000_000A
`define SHS_TIME_LIM_RST 16'h2710
// ==========================================================
// Timing: one millisecond at the reference clock
`define SHS_CLK_HZ 200000000
`define SHS_MS_PER_S 1000
`endif

// [rtl/shs_pkg.sv]
// Types shared by the servo homing sequencer
package shs_pkg;
  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    SHS_IDLE = 4'b0000,
    SHS_SEEK = 4'b0001,
    SHS_BACK = 4'b0010,
    SHS_PASS = 4'b0011,
    SHS_FINE = 4'b0100,
    SHS_ZSEEK = 4'b0101,
    SHS_OFFSET = 4'b0110,
    SHS_DONE = 4'b0111,
    SHS_FAULT = 4'b1000
  } shs_state_type;
  // ==========================================================
  // Sampled field inputs
  typedef struct packed {
    logic home_sw;
    logic pos_limit;
    logic neg_limit;
    logic index_pulse;
  } shs_sense_type;
  // ==========================================================
  // Motion command to the profile generator
  typedef struct packed {
    logic run;
    logic reverse;
    logic [31:0] speed;
  } shs_motion_type;
endpackage

// [rtl/shs_sequencer.sv]
// Servo homing sequencer with APB register access
// What this block does
// - Electrical homing on enable after a zero was found; trigger clears afterwards
// - Current-position trigger takes present position as home; zero offset gives zero
// - Nonzero offset: mode 0 feedback equals offset, mode 1 position plus offset
// - Current-position trigger clears after completion; rewrite 6 and re-enable
// - Method 0 below switch: fast forward, fast reverse, slow forward to edge
// - Method 0 on switch: fast reverse, slow forward, stop on rising edge
// - Method 0 above switch: forward to limit, reverse, slow forward to edge
// - Method 1 below switch: reverse to limit, fast forward, slow reverse to edge
// - Method 1 on switch: fast forward, slow reverse, stop on rising edge
// - Method 1 above switch: reverse, forward past switch, slow reverse to edge
// - Method 2: slow forward, stop on index rising edge
// - Methods 2 and 3 already on index: latch position and stop
// - Method 2 no index: forward, reverse at limit, forward after index fall
// - Method 3: slow reverse, stop on index rising edge
// - Method 3 no index: reverse, forward at limit, reverse after index fall
// - Method 4 below switch: fast forward, slow forward at switch, stop on index
// - Method 4 on switch: reverse, forward, slow forward at switch to index
// - Method 4 above switch: forward to limit, reverse, forward, slow to index
// - Method selection also accepts standard methods 1 to 34 when enabled
// - Active output high while homing; done output once offset is reached, or at once for the current-position trigger
// - Exceeding the time limit aborts with a timeout fault
`include "shs_consts.svh"
module shs_sequencer #(
  parameter int CIA_METHODS = 1,
  parameter int CLK_PER_MS = `SHS_CLK_HZ / `SHS_MS_PER_S
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire shs_pkg::shs_sense_type i_sense,
  input wire logic [31:0] i_position,
  input wire logic i_offset_reached,
  output shs_pkg::shs_motion_type o_motion,
  output logic o_set_position,
  output logic [31:0] o_new_position,
  output logic o_homing_active_output,
  output logic o_homing_done_output,
  output logic o_homing_timeout_fault
);
  import shs_pkg::*;

  // Parameters that the logic cannot serve stop elaboration
  if (CLK_PER_MS < 1 || CIA_METHODS < 0 || CIA_METHODS > 1)
  begin : g_param_check
    $error("shs_sequencer: unsupported parameters");
  end
  // ==========================================================
  // Registers
  logic [1:0] ctrl;
  logic [2:0] homing_trigger_select;
  logic [5:0] homing_method_select;
  logic [31:0] home_offset;
  logic [31:0] high_speed;
  logic [31:0] low_speed;
  logic [15:0] time_limit;
  logic [31:0] position_fb;
  logic zero_found;
  logic enable_q;
  shs_state_type state;
  shs_sense_type sense_q;
  logic [31:0] ms_div;
  logic [15:0] ms_count;
  logic is_elec;
  logic wr_en;
  logic rd_en;
  logic method_ok;
  logic enable_rise;
  logic finish;
  shs_sense_type rise;
  shs_sense_type fall;

  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && !i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign enable_rise = ctrl[`SHS_CTRL_ENABLE] && !enable_q;

  assign method_ok = (i_pwdata[5:0] <= `SHS_METHOD_MAX)
    || (CIA_METHODS != 0 && i_pwdata[5:0] <= `SHS_METHOD_CIA_MAX);

  assign rise = i_sense & ~sense_q;
  assign fall = ~i_sense & sense_q;

  // Unmapped address answers with an error
  always_comb
  begin
    if (i_paddr == `SHS_OFF_CTRL) o_pslverr = 1'b0;
    else if (i_paddr == `SHS_OFF_TRIG) o_pslverr = 1'b0;
    else if (i_paddr == `SHS_OFF_METHOD) o_pslverr = 1'b0;
    else if (i_paddr == `SHS_OFF_OFFSET) o_pslverr = 1'b0;
    else if (i_paddr == `SHS_OFF_HIGH_SPD) o_pslverr = 1'b0;
    else if (i_paddr == `SHS_OFF_LOW_SPD) o_pslverr = 1'b0;
    else if (i_paddr == `SHS_OFF_TIME_LIM) o_pslverr = 1'b0;
    else if (i_paddr == `SHS_OFF_STATUS) o_pslverr = 1'b0;
    else if (i_paddr == `SHS_OFF_POS_FB) o_pslverr = 1'b0;
    else o_pslverr = i_psel && i_penable;
  end

  // Configuration writes
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ctrl <= 2'h0;
      homing_method_select <= 6'h00;
      home_offset <= 32'h0000_0000;
      high_speed <= `SHS_HIGH_SPD_RST;
      low_speed <= `SHS_LOW_SPD_RST;
      time_limit <= `SHS_TIME_LIM_RST;
    end
    else if (wr_en)
    begin
      if (i_paddr == `SHS_OFF_CTRL) ctrl <= i_pwdata[1:0];
      else if (i_paddr == `SHS_OFF_METHOD && method_ok) homing_method_select <= i_pwdata[5:0];
      else if (i_paddr == `SHS_OFF_OFFSET) home_offset <= i_pwdata;
      else if (i_paddr == `SHS_OFF_HIGH_SPD) high_speed <= i_pwdata;
      else if (i_paddr == `SHS_OFF_LOW_SPD) low_speed <= i_pwdata;
      else if (i_paddr == `SHS_OFF_TIME_LIM) time_limit <= i_pwdata[15:0];
    end
  end

  // Trigger select: hardware clear wins over a write in the same cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      homing_trigger_select <= `SHS_TRIG_NONE;
    else if (finish && homing_trigger_select != `SHS_TRIG_NONE)
      homing_trigger_select <= `SHS_TRIG_NONE;
    else if (wr_en && i_paddr == `SHS_OFF_TRIG)
      homing_trigger_select <= i_pwdata[2:0];
  end

  // Read data loaded in the setup cycle, so it stands through the access phase
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_prdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      if (i_paddr == `SHS_OFF_CTRL) o_prdata <= {30'h0, ctrl};
      else if (i_paddr == `SHS_OFF_TRIG) o_prdata <= {29'h0, homing_trigger_select};
      else if (i_paddr == `SHS_OFF_METHOD) o_prdata <= {26'h0, homing_method_select};
      else if (i_paddr == `SHS_OFF_OFFSET) o_prdata <= home_offset;
      else if (i_paddr == `SHS_OFF_HIGH_SPD) o_prdata <= high_speed;
      else if (i_paddr == `SHS_OFF_LOW_SPD) o_prdata <= low_speed;
      else if (i_paddr == `SHS_OFF_TIME_LIM) o_prdata <= {16'h0, time_limit};
      else if (i_paddr == `SHS_OFF_STATUS)
        o_prdata <= {23'h0, zero_found, o_homing_timeout_fault, o_homing_done_output,
                     o_homing_active_output, 1'b0, state};
      else if (i_paddr == `SHS_OFF_POS_FB) o_prdata <= position_fb;
      else o_prdata <= 32'h0000_0000;
    end
  end

  // Input sampling and enable edge
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      sense_q <= '0;
      enable_q <= 1'b0;
    end
    else
    begin
      sense_q <= i_sense;
      enable_q <= ctrl[`SHS_CTRL_ENABLE];
    end
  end

  assign finish = ((state == SHS_OFFSET) && i_offset_reached && ctrl[`SHS_CTRL_ENABLE])
    || ((state == SHS_IDLE) && enable_rise && homing_trigger_select == `SHS_TRIG_CURPOS);

  // ==========================================================
  // Sequencer
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state <= SHS_IDLE;
      o_motion <= '0;
      is_elec <= 1'b0;
      zero_found <= 1'b0;
      position_fb <= 32'h0000_0000;
      o_set_position <= 1'b0;
      o_new_position <= 32'h0000_0000;
    end
    else
    begin
      o_set_position <= 1'b0;
      if (!ctrl[`SHS_CTRL_ENABLE] && state != SHS_IDLE)
      begin
        state <= SHS_IDLE;
        o_motion.run <= 1'b0;
      end
      else
        case (state)
          SHS_IDLE:
            if (enable_rise)
            begin
              if (homing_trigger_select == `SHS_TRIG_CURPOS)
              begin
                o_set_position <= 1'b1;
                if (home_offset == 32'h0) o_new_position <= 32'h0;
                else if (ctrl[`SHS_CTRL_APPLY_MODE]) o_new_position <= i_position + home_offset;
                else o_new_position <= home_offset;
                position_fb <= (home_offset == 32'h0) ? 32'h0 :
                  (ctrl[`SHS_CTRL_APPLY_MODE] ? i_position + home_offset : home_offset);
                zero_found <= 1'b1;
                state <= SHS_DONE;
              end
              // electrical homing runs to the zero point
              else if (homing_trigger_select == `SHS_TRIG_ELEC && zero_found)
              begin
                is_elec <= 1'b1;
                o_motion <= '{1'b1, ~i_position[31], high_speed};
                state <= SHS_OFFSET;
              end
              else if (homing_trigger_select != `SHS_TRIG_NONE)
              begin
                is_elec <= 1'b0;
                if ((homing_method_select == 6'h02 || homing_method_select == 6'h03)
                    && i_sense.index_pulse)
                begin
                  position_fb <= 32'h0;
                  o_set_position <= 1'b1;
                  o_new_position <= 32'h0;
                  o_motion <= '{1'b1, home_offset[31], low_speed};
                  state <= SHS_OFFSET;
                end
                else if (homing_method_select == 6'h02)
                begin
                  o_motion <= '{1'b1, 1'b0, low_speed};
                  state <= SHS_ZSEEK;
                end
                else if (homing_method_select == 6'h03)
                begin
                  o_motion <= '{1'b1, 1'b1, low_speed};
                  state <= SHS_ZSEEK;
                end
                else if (i_sense.home_sw)
                begin
                  o_motion <= '{1'b1, (homing_method_select != 6'h01), high_speed};
                  state <= SHS_BACK;
                end
                else
                begin
                  o_motion <= '{1'b1, (homing_method_select == 6'h01), high_speed};
                  state <= SHS_SEEK;
                end
              end
            end
          SHS_SEEK:
            if (rise.home_sw)
            begin
              if (homing_method_select == 6'h04)
              begin
                o_motion <= '{1'b1, 1'b0, low_speed};
                state <= SHS_ZSEEK;
              end
              else
              begin
                o_motion.reverse <= ~o_motion.reverse;
                state <= SHS_BACK;
              end
            end
            else if ((rise.pos_limit && !o_motion.reverse) || (rise.neg_limit && o_motion.reverse))
            begin
              o_motion.reverse <= ~o_motion.reverse;
              state <= SHS_BACK;
            end
          SHS_BACK:
            if (fall.home_sw)
            begin
              if (homing_method_select == 6'h04)
              begin
                o_motion <= '{1'b1, 1'b0, high_speed};
                state <= SHS_PASS;
              end
              else
              begin
                o_motion <= '{1'b1, (homing_method_select == 6'h01), low_speed};
                state <= SHS_FINE;
              end
            end
          SHS_PASS:
            if (rise.home_sw)
            begin
              o_motion <= '{1'b1, 1'b0, low_speed};
              state <= SHS_ZSEEK;
            end
          SHS_FINE:
            if (rise.home_sw)
            begin
              position_fb <= 32'h0;
              o_set_position <= 1'b1;
              o_new_position <= 32'h0;
              o_motion <= '{1'b1, home_offset[31], low_speed};
              state <= SHS_OFFSET;
            end
          SHS_ZSEEK:
            if (rise.index_pulse && !is_elec)
            begin
              position_fb <= 32'h0;
              o_set_position <= 1'b1;
              o_new_position <= 32'h0;
              o_motion <= '{1'b1, home_offset[31], low_speed};
              state <= SHS_OFFSET;
            end
            else if ((rise.pos_limit && !o_motion.reverse) || (rise.neg_limit && o_motion.reverse))
            begin
              o_motion.reverse <= ~o_motion.reverse;
              is_elec <= 1'b1;
            end
            else if (fall.index_pulse && is_elec)
            begin
              o_motion.reverse <= ~o_motion.reverse;
              is_elec <= 1'b0;
            end
          SHS_OFFSET:
            if (i_offset_reached)
            begin
              o_motion.run <= 1'b0;
              zero_found <= 1'b1;
              state <= SHS_DONE;
            end
          SHS_DONE:
            o_motion.run <= 1'b0;
          default:
            o_motion.run <= 1'b0;
        endcase
      if (ms_count >= time_limit && o_homing_active_output && ctrl[`SHS_CTRL_ENABLE])
      begin
        state <= SHS_FAULT;
        o_motion.run <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || !o_homing_active_output)
    begin
      ms_div <= 32'h0;
      ms_count <= 16'h0;
    end
    else if (ms_div == 32'(CLK_PER_MS - 1))
    begin
      ms_div <= 32'h0;
      if (ms_count != 16'hFFFF) ms_count <= ms_count + 16'h1;
    end
    else
      ms_div <= ms_div + 32'h1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_homing_active_output <= 1'b0;
      o_homing_done_output <= 1'b0;
      o_homing_timeout_fault <= 1'b0;
    end
    else
    begin
      o_homing_active_output <= (state != SHS_IDLE) && (state != SHS_DONE)
        && (state != SHS_FAULT);
      o_homing_done_output <= (state == SHS_DONE);
      o_homing_timeout_fault <= (state == SHS_FAULT);
    end
  end
endmodule // shs_sequencer

// [bench/shs_sequencer_props.sv]
// Port-level assertions for the servo homing sequencer
`include "shs_consts.svh"
module shs_sequencer_props
  import shs_pkg::*;
#(
  parameter int CLK_PER_MS = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire shs_pkg::shs_motion_type o_motion,
  input wire logic o_set_position,
  input wire logic o_homing_active_output,
  input wire logic o_homing_done_output,
  input wire logic o_homing_timeout_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] hi_spd;
  logic [31:0] lo_spd;
  logic [15:0] lim;
  logic en;
  logic wr;
  int unsigned act_cnt;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  assign wr = i_psel && i_penable && i_pwrite;
  // ==========================================================
  // Shadow of the registers that the checks depend on
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      hi_spd <= `SHS_HIGH_SPD_RST;
      lo_spd <= `SHS_LOW_SPD_RST;
      lim <= `SHS_TIME_LIM_RST;
      en <= 1'b0;
    end
    else if (wr)
    begin
      if (i_paddr == `SHS_OFF_HIGH_SPD)
        hi_spd <= i_pwdata;
      if (i_paddr == `SHS_OFF_LOW_SPD)
        lo_spd <= i_pwdata;
      if (i_paddr == `SHS_OFF_TIME_LIM)
        lim <= i_pwdata[15:0];
      if (i_paddr == `SHS_OFF_CTRL)
        en <= i_pwdata[0];
    end
  end
  // Length of the current homing run in cycles
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || !o_homing_active_output)
      act_cnt <= 32'h0;
    else
      act_cnt <= act_cnt + 32'h1;
  end
  sequence s_released;
    !o_homing_active_output && !o_homing_done_output;
  endsequence
  // ==========================================================
  // Assertions
  a_pready_high: assert property (o_pready)
    else $error("pready low");
  a_slverr_map: assert property (i_psel && i_penable && i_paddr[1:0] == 2'h0
    |-> o_pslverr == (i_paddr > `SHS_OFF_POS_FB))
    else $error("slave error does not match address map");
  a_done_excl: assert property ($rose(o_homing_done_output) |-> !o_homing_active_output)
    else $error("done raised while active");
  a_enable_idle: assert property ($fell(en) |-> ##[1:3] s_released)
    else $error("outputs not released after disable");
  a_set_pulse: assert property (o_set_position |=> !o_set_position)
    else $error("set position longer than one cycle");
  a_speed_sel: assert property (o_motion.run |-> o_motion.speed == hi_spd
    || o_motion.speed == lo_spd)
    else $error("motion speed is not a configured setpoint");
  a_active_bound: assert property (act_cnt <= lim * CLK_PER_MS + 16)
    else $error("homing exceeded time limit");
  a_fault_excl: assert property (o_homing_timeout_fault |-> !o_homing_done_output)
    else $error("fault and done together");
  a_run_needs_en: assert property (o_motion.run |-> en || $past(en) || $past(en, 2))
    else $error("motion while disabled");
endmodule // shs_sequencer_props

// [bench/shs_axis_model.sv]
// Behavioural axis: profile generator, switches and encoder index
module shs_axis_model
  import shs_pkg::*;
#(
  parameter int HS_LO = 32'h28,
  parameter int HS_HI = 32'h64,
  parameter int LIM = 32'h12C
) (
  input wire logic i_ref_clk,
  input wire logic i_load,
  input wire logic [31:0] i_start,
  input wire shs_pkg::shs_motion_type i_motion,
  input wire logic i_set_position,
  output shs_pkg::shs_sense_type o_sense,
  output logic [31:0] o_position,
  output logic o_offset_reached
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [31:0] p;
  logic [2:0] settle;
  assign p = o_position;
  // Axis moves one count per cycle while commanded
  always_ff @(posedge i_ref_clk)
  begin
    if (i_load)
      o_position <= i_start;
    else if (i_motion.run)
      o_position <= i_motion.reverse ? o_position - 32'h1 : o_position + 32'h1;
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (i_load)
      settle <= 3'h0;
    else if (i_set_position)
      settle <= 3'h4;
    else if (settle != 3'h0)
      settle <= settle - 3'h1;
  end
  assign o_offset_reached = (settle == 3'h0) && !i_set_position;
  // Home switch band, end limits and an index mark every 64 counts
  assign o_sense.home_sw = p >= HS_LO && p <= HS_HI;
  assign o_sense.pos_limit = p >= LIM;
  assign o_sense.neg_limit = p <= -LIM;
  assign o_sense.index_pulse = o_position[5:0] == 6'h00;
endmodule // shs_axis_model

// [bench/testbench.sv]
// Self-checking bench for the servo homing sequencer
`include "shs_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import shs_pkg::*;
  localparam int HS_LO = 32'h28;
  localparam int HS_HI = 32'h64;
  localparam int LIM = 32'h12C;
  logic i_ref_clk, i_rst, i_psel, i_penable, i_pwrite, ld, err, act;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, i_position, o_new_position, st, rd, hp, hn, s, off;
  logic o_pready, o_pslverr, o_set_position, i_offset_reached;
  logic o_homing_active_output, o_homing_done_output, o_homing_timeout_fault;
  shs_sense_type i_sense;
  shs_motion_type o_motion;
  int n_errors = 0;
  int checks = 0;
  shs_sequencer #(.CIA_METHODS(1), .CLK_PER_MS(10)) uut (.i_ref_clk, .i_rst, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_sense,
    .i_position, .i_offset_reached, .o_motion, .o_set_position, .o_new_position,
    .o_homing_active_output, .o_homing_done_output, .o_homing_timeout_fault);
  shs_axis_model #(.HS_LO(HS_LO), .HS_HI(HS_HI), .LIM(LIM)) axis (.i_ref_clk, .i_load(ld),
    .i_start(st), .i_motion(o_motion), .i_set_position(o_set_position), .o_sense(i_sense),
    .o_position(i_position), .o_offset_reached(i_offset_reached));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_ref_clk);
    end
    while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // Register read; data taken at the pready edge
  task automatic rdreg(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic place(input logic [31:0] p);
    @(posedge i_ref_clk);
    st <= p;
    ld <= 1'b1;
    @(posedge i_ref_clk);
    ld <= 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    act = 1'b0;
    while (o_homing_done_output !== 1'b1 && n < 4000)
    begin
      @(posedge i_ref_clk);
      n++;
      if (o_homing_active_output === 1'b1)
        act = 1'b1;
      if (o_set_position === 1'b1)
      begin
        hp = i_position;
        hn = o_new_position;
      end
    end
    chk("homing done", {31'h0, o_homing_done_output}, 32'h1);
  endtask
  function automatic logic [31:0] exp_home(input int m, input int v);
    case (m)
      0: return HS_LO;
      1: return HS_HI;
      2: return (v + 32'h3F) & 32'hFFFF_FFC0;
      3: return v & 32'hFFFF_FFC0;
      default: return 32'h40;
    endcase
  endfunction
  function automatic logic [31:0] pick(input int r);
    case (r)
      0: return $urandom_range(32'h10E, 32'h0) - 32'hFA;
      1: return $urandom_range(32'h5F, 32'h2D);
      default: return $urandom_range(32'hFA, 32'h6E);
    endcase
  endfunction
  task automatic home(input logic [5:0] m, input logic [31:0] e, input logic rev);
    logic [31:0] d;
    apb(1'b1, `SHS_OFF_METHOD, {26'h0, m});
    place(s);
    apb(1'b1, `SHS_OFF_TRIG, 32'h4);
    apb(1'b1, `SHS_OFF_CTRL, 32'h1);
    wait_done();
    d = rev ? e - hp : hp - e;
    chk("home position", {31'h0, d < 32'h5}, 32'h1);
    chk("feedback zero", hn, 32'h0);
    chk("active seen", {31'h0, act}, 32'h1);
    apb(1'b1, `SHS_OFF_CTRL, 32'h0);
  endtask
  initial
  begin
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    ld = 1'b1;
    st = 32'h0;
    void'($urandom(32'h5CBB3B93));
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    ld <= 1'b0;
    rdreg(`SHS_OFF_HIGH_SPD);
    chk("high speed", rd, `SHS_HIGH_SPD_RST);
    rdreg(`SHS_OFF_LOW_SPD);
    chk("low speed", rd, `SHS_LOW_SPD_RST);
    rdreg(`SHS_OFF_TIME_LIM);
    chk("time limit", rd, {16'h0, `SHS_TIME_LIM_RST});
    rdreg(12'h040);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, `SHS_OFF_METHOD, 32'h22);
    apb(1'b1, `SHS_OFF_METHOD, 32'h23);
    rdreg(`SHS_OFF_METHOD);
    chk("method limit", rd, 32'h22);
    $display("registers done");
    apb(1'b1, `SHS_OFF_TIME_LIM, 32'h1F4);
    for (int m = 0; m < 5; m++)
      for (int r = 0; r < 3; r++)
      begin
        s = pick(r);
        home(m[5:0], exp_home(m, s), m == 1 || m == 3);
        $display("method %0d start %0d done", m, $signed(s));
      end
    s = 32'h80;
    home(6'h2, 32'h80, 1'b0);
    s = 32'h110;
    home(6'h2, 32'h100, 1'b0);
    s = 32'hFFFF_FEF0;
    home(6'h3, 32'hFFFF_FF00, 1'b1);
    $display("limit turnaround done");
    for (int k = 0; k < 3; k++)
    begin
      off = (k == 0) ? 32'h0 : $urandom_range(32'hFFFF, 32'h1);
      apb(1'b1, `SHS_OFF_OFFSET, off);
      apb(1'b1, `SHS_OFF_TRIG, 32'h6);
      apb(1'b1, `SHS_OFF_CTRL, {30'h0, k == 2, 1'b1});
      wait_done();
      chk("feedback", hn, (k == 2) ? hp + off : off);
      rdreg(`SHS_OFF_TRIG);
      chk("trigger cleared", rd, 32'h0);
      apb(1'b1, `SHS_OFF_CTRL, 32'h0);
    end
    $display("current position done");
    rdreg(`SHS_OFF_STATUS);
    chk("zero found", {31'h0, rd[8]}, 32'h1);
    place(32'h50);
    apb(1'b1, `SHS_OFF_TRIG, 32'h5);
    apb(1'b1, `SHS_OFF_CTRL, 32'h1);
    wait_done();
    rdreg(`SHS_OFF_TRIG);
    chk("electrical cleared", rd, 32'h0);
    apb(1'b1, `SHS_OFF_CTRL, 32'h0);
    $display("electrical done");
    apb(1'b1, `SHS_OFF_TIME_LIM, 32'h1);
    apb(1'b1, `SHS_OFF_METHOD, 32'h0);
    place(32'hFFFF_FF06);
    apb(1'b1, `SHS_OFF_TRIG, 32'h4);
    apb(1'b1, `SHS_OFF_CTRL, 32'h1);
    repeat (40) @(posedge i_ref_clk);
    chk("timeout fault", {31'h0, o_homing_timeout_fault}, 32'h1);
    $display("timeout done");
    test_done();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #300000;
    n_errors++;
    test_done();
  end
endmodule // testbench
bind shs_sequencer shs_sequencer_props #(.CLK_PER_MS(CLK_PER_MS)) u_props (.i_ref_clk,
  .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr,
  .o_motion, .o_set_position, .o_homing_active_output, .o_homing_done_output,
  .o_homing_timeout_fault);
